// ### rtl/tptr_pkg.sv
package tptr_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_WR_ADDR  = 8'hf2;
  localparam logic [7:0] IDX_WR_DATA  = 8'hf3;
  localparam logic [7:0] IDX_NEG_TRIM = 8'hf4;
  localparam logic [7:0] IDX_POS_TRIM = 8'hf5;
  localparam logic [7:0] IDX_SRC_SEL  = 8'hf6;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_UI_LSB     = 0;
  localparam int unsigned ADDR_SAMPLE_LSB = 3;
  localparam int unsigned TRIM_EN_BIT     = 0;
  localparam int unsigned TRIM_MAG_LSB    = 1;
  localparam int unsigned TRIM_DIR_BIT    = 6;
  localparam int unsigned SRC_SEL_BIT     = 0;
  localparam int unsigned TPL_SIGN_BIT    = 6;

  // ---------------------------------------------------------------
  // sizes, limits and reset values
  // ---------------------------------------------------------------
  localparam int unsigned UI_COUNT       = 5;
  localparam int unsigned SAMPLE_COUNT   = 24;
  localparam int unsigned TEMPLATE_DEPTH = 120;
  localparam logic [2:0]  UI_MAX         = 3'h4;
  localparam logic [4:0]  SAMPLE_MAX     = 5'h17;
  localparam logic [6:0]  TPL_BAD_CODE   = 7'h7f;
  localparam logic [7:0]  WR_ADDR_RST    = 8'h00;
  localparam logic [6:0]  TRIM_RST       = 7'h00;
  localparam logic        SRC_SEL_RST    = 1'b0;
  localparam logic [6:0]  TPL_RST        = 7'h00;

  typedef logic [6:0] tptr_tpl_idx_t;
  typedef logic [6:0] tptr_sample_t;

  // flat template index from unit interval and sample
  function automatic tptr_tpl_idx_t tptr_tpl_index(input logic [2:0] ui,
                                                   input logic [4:0] sample);
    tptr_tpl_index = 7'(int'(ui) * int'(SAMPLE_COUNT) + int'(sample));
  endfunction : tptr_tpl_index

  // both selectors within their defined ranges
  function automatic logic tptr_addr_ok(input logic [2:0] ui,
                                        input logic [4:0] sample);
    tptr_addr_ok = (ui <= UI_MAX) && (sample <= SAMPLE_MAX);
  endfunction : tptr_addr_ok

  // sign-magnitude to two's complement
  function automatic tptr_sample_t tptr_sm_to_twos(input tptr_sample_t sm);
    tptr_sm_to_twos = sm[TPL_SIGN_BIT] ? 7'(-{1'b0, sm[5:0]}) : {1'b0, sm[5:0]};
  endfunction : tptr_sm_to_twos

endpackage : tptr_pkg

// ### rtl/tptr_wr_if.sv
`timescale 1ns/1ns
// write-side signals shared by the storage modules
interface tptr_wr_if;
  logic       hold;
  logic [7:0] wdata;
  logic       tpl_we;
  logic [2:0] ui;
  logic [4:0] sample;
  logic       any_we;
  logic       src_sel;

  modport src (output hold, output wdata, output tpl_we, output ui, output sample,
               output any_we, output src_sel);
  modport dst (input hold, input wdata, input tpl_we, input ui, input sample,
               input any_we, input src_sel);
endinterface : tptr_wr_if

// ### rtl/tptr_template_mem.sv
`timescale 1ns/1ns
module tptr_template_mem (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  tptr_wr_if.dst          wr,
  input  wire logic [2:0] rd_ui_i,
  input  wire logic [4:0] rd_sample_i,
  output logic [6:0]      rd_data_o
);

  logic [6:0] mem_r [tptr_pkg::TEMPLATE_DEPTH];
  logic       wr_ok;

  // defined address and legal code only
  assign wr_ok = wr.tpl_we && tptr_pkg::tptr_addr_ok(wr.ui, wr.sample)  // RULE1 RULE2 RULE14
                 && (wr.wdata[6:0] != tptr_pkg::TPL_BAD_CODE);          // RULE5

  // template storage, cleared while powered down
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < int'(tptr_pkg::TEMPLATE_DEPTH); i++)
        mem_r[i] <= tptr_pkg::TPL_RST;
    end
    else if (wr.hold)
    begin
      for (int i = 0; i < int'(tptr_pkg::TEMPLATE_DEPTH); i++)
        mem_r[i] <= tptr_pkg::TPL_RST;  // RULE6
    end
    else if (wr_ok)
      mem_r[tptr_pkg::tptr_tpl_index(wr.ui, wr.sample)] <= wr.wdata[6:0];  // RULE4
  end

  // registered read port in two's complement
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rd_data_o <= tptr_pkg::TPL_RST;
    else if (!tptr_pkg::tptr_addr_ok(rd_ui_i, rd_sample_i))
      rd_data_o <= tptr_pkg::TPL_RST;
    else
      rd_data_o <= tptr_pkg::tptr_sm_to_twos(
                     mem_r[tptr_pkg::tptr_tpl_index(rd_ui_i, rd_sample_i)]);  // RULE5
  end

endmodule : tptr_template_mem

// ### rtl/tptr_trim_reg.sv
`timescale 1ns/1ns
module tptr_trim_reg (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  tptr_wr_if.dst          wr,
  input  wire logic       trim_we_i,
  input  wire logic [5:0] fuse_value_i,
  output logic [6:0]      trim_o,
  output logic            fuse_sense_o
);

  typedef enum logic {FUSE_IDLE, FUSE_ARMED} tptr_fuse_state_t;
  tptr_fuse_state_t state_r;

  // trim value and fuse copy sequence
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      trim_o  <= tptr_pkg::TRIM_RST;
      state_r <= FUSE_IDLE;
    end
    else if (wr.hold)
    begin
      trim_o  <= tptr_pkg::TRIM_RST;  // RULE6
      state_r <= FUSE_IDLE;
    end
    else if (trim_we_i && wr.src_sel)
    begin
      trim_o  <= wr.wdata[6:0];  // RULE11 RULE7 RULE10
      state_r <= FUSE_IDLE;
    end
    else if (trim_we_i)
    begin
      case (state_r)
        FUSE_IDLE:
          state_r <= FUSE_ARMED;  // RULE11 RULE12
        FUSE_ARMED:
        begin
          trim_o  <= {fuse_value_i, trim_o[tptr_pkg::TRIM_EN_BIT]};  // RULE11 RULE12
          state_r <= FUSE_IDLE;
        end
        default:
          state_r <= FUSE_IDLE;
      endcase
    end
    else if (wr.any_we)
      state_r <= FUSE_IDLE;  // copy needs two writes in a row
  end

  // fuse interface outputs active while armed
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      fuse_sense_o <= 1'b0;
    else if (wr.hold)
      fuse_sense_o <= 1'b0;
    else if (trim_we_i && !wr.src_sel)
      fuse_sense_o <= (state_r == FUSE_IDLE);
    else if (wr.any_we)
      fuse_sense_o <= 1'b0;
  end

endmodule : tptr_trim_reg

// ### rtl/tptr_top.sv
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ns
// Operation
// RULE1: unit interval selector uses 0 to 4; 5 to 7 undefined.
// RULE2: sample selector uses 0x00 to 0x17; 0x18 to 0x1f undefined.
// RULE3: address register: sample in bits 7:3, unit interval in 2:0, reset zero.
// RULE4: write address first, then each data write stores one of 120 entries.
// RULE5: template data is sign-magnitude, bit 6 sign; -63 is not allowed.
// RULE6: power-down bit high holds every register of the block in reset; template read data clears a cycle late, bus ack/data are not reset.
// RULE7: negative trim: bits 5:1 magnitude, bit 6 direction, bit 0 enable low.
// RULE8: enable low and fuse pin high blows fuses, only in analog test mode.
// RULE9: enable low and fuse pin low makes bits 6:1 override the fuses.
// RULE10: positive trim register has the same layout and fuse behaviour.
// RULE11: source select picks bus data at one, burned fuse values at zero.
// RULE12: software sets enables, writes each trim twice to copy fuse data.
// RULE13: software should clear both enables afterwards against fuse regrowth.
// RULE14: data write with an undefined selector leaves all entries unchanged.
module tptr_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        tx_line_if_powerdown_i,
  input  wire logic        analog_test_mode_i,
  input  wire logic        fuse_blow_pin_i,
  input  wire logic [5:0]  neg_fuse_value_i,
  input  wire logic [5:0]  pos_fuse_value_i,
  output logic [6:0]       neg_current_trim_o,
  output logic [6:0]       pos_current_trim_o,
  output logic [5:0]       neg_fuse_blow_o,
  output logic [5:0]       pos_fuse_blow_o,
  output logic             neg_fuse_override_o,
  output logic             pos_fuse_override_o,
  output logic             neg_fuse_sense_o,
  output logic             pos_fuse_sense_o,
  input  wire logic [2:0]  tpl_rd_ui_i,
  input  wire logic [4:0]  tpl_rd_sample_i,
  output logic [6:0]       tpl_rd_data_o
);

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  tptr_wr_if wr ();

  logic       wb_req;
  logic       wr_en;
  logic [7:0] idx;
  logic       in_range;
  logic [7:0] wr_addr_r;
  logic       src_sel_r;
  logic [6:0] neg_trim;
  logic [6:0] pos_trim;
  logic [7:0] rd_byte;

  // new request only while no answer is out
  assign wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign idx      = wb_adr_i[9:2];
  assign in_range = (wb_adr_i[11:10] == 2'h0) && (wb_adr_i[1:0] == 2'h0);
  assign wr_en    = wb_req && wb_we_i && wb_sel_i[0] && in_range;

  // ---------------------------------------------------------------
  // write-side carrier
  // ---------------------------------------------------------------
  assign wr.hold    = tx_line_if_powerdown_i;
  assign wr.wdata   = wb_dat_i[7:0];
  assign wr.tpl_we  = wr_en && (idx == tptr_pkg::IDX_WR_DATA);  // RULE4
  assign wr.ui      = wr_addr_r[tptr_pkg::ADDR_UI_LSB +: 3];       // RULE3
  assign wr.sample  = wr_addr_r[tptr_pkg::ADDR_SAMPLE_LSB +: 5];   // RULE3
  assign wr.any_we  = wr_en;
  assign wr.src_sel = src_sel_r;

  // ---------------------------------------------------------------
  // address and source select registers
  // ---------------------------------------------------------------
  // template write address
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      wr_addr_r <= tptr_pkg::WR_ADDR_RST;
    else if (tx_line_if_powerdown_i)
      wr_addr_r <= tptr_pkg::WR_ADDR_RST;  // RULE6
    else if (wr_en && (idx == tptr_pkg::IDX_WR_ADDR))
      wr_addr_r <= wb_dat_i[7:0];  // RULE3
  end

  // trim source select
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      src_sel_r <= tptr_pkg::SRC_SEL_RST;
    else if (tx_line_if_powerdown_i)
      src_sel_r <= tptr_pkg::SRC_SEL_RST;  // RULE6
    else if (wr_en && (idx == tptr_pkg::IDX_SRC_SEL))
      src_sel_r <= wb_dat_i[tptr_pkg::SRC_SEL_BIT];  // RULE11
  end

  // ---------------------------------------------------------------
  // storage modules
  // ---------------------------------------------------------------
  tptr_template_mem u_tpl (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .wr          (wr),
    .rd_ui_i     (tpl_rd_ui_i),
    .rd_sample_i (tpl_rd_sample_i),
    .rd_data_o   (tpl_rd_data_o)
  );

  tptr_trim_reg u_neg (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .wr           (wr),
    .trim_we_i    (wr_en && (idx == tptr_pkg::IDX_NEG_TRIM)),
    .fuse_value_i (neg_fuse_value_i),
    .trim_o       (neg_trim),
    .fuse_sense_o (neg_fuse_sense_o)
  );

  tptr_trim_reg u_pos (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .wr           (wr),
    .trim_we_i    (wr_en && (idx == tptr_pkg::IDX_POS_TRIM)),
    .fuse_value_i (pos_fuse_value_i),
    .trim_o       (pos_trim),
    .fuse_sense_o (pos_fuse_sense_o)
  );

  assign neg_current_trim_o = neg_trim;  // RULE7
  assign pos_current_trim_o = pos_trim;  // RULE10

  // ---------------------------------------------------------------
  // fuse blow and override drive
  // ---------------------------------------------------------------
  // blow only in test mode with pin high; override with pin low
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      neg_fuse_blow_o     <= 6'h00;
      pos_fuse_blow_o     <= 6'h00;
      neg_fuse_override_o <= 1'b0;
      pos_fuse_override_o <= 1'b0;
    end
    else if (tx_line_if_powerdown_i)
    begin
      neg_fuse_blow_o     <= 6'h00;
      pos_fuse_blow_o     <= 6'h00;
      neg_fuse_override_o <= 1'b0;
      pos_fuse_override_o <= 1'b0;
    end
    else
    begin
      neg_fuse_blow_o <= (!neg_trim[tptr_pkg::TRIM_EN_BIT] && fuse_blow_pin_i
                          && analog_test_mode_i) ? neg_trim[6:1] : 6'h00;  // RULE8
      pos_fuse_blow_o <= (!pos_trim[tptr_pkg::TRIM_EN_BIT] && fuse_blow_pin_i
                          && analog_test_mode_i) ? pos_trim[6:1] : 6'h00;  // RULE8 RULE10
      neg_fuse_override_o <= !neg_trim[tptr_pkg::TRIM_EN_BIT] && !fuse_blow_pin_i;  // RULE9
      pos_fuse_override_o <= !pos_trim[tptr_pkg::TRIM_EN_BIT] && !fuse_blow_pin_i;  // RULE9 RULE10
    end
  end

  // ---------------------------------------------------------------
  // read mux and answer
  // ---------------------------------------------------------------
  // data register is write only and reads zero
  always_comb
  begin
    rd_byte = 8'h00;
    if (in_range)
    begin
      case (idx)
        tptr_pkg::IDX_WR_ADDR:  rd_byte = wr_addr_r;
        tptr_pkg::IDX_NEG_TRIM: rd_byte = {1'b0, neg_trim};
        tptr_pkg::IDX_POS_TRIM: rd_byte = {1'b0, pos_trim};
        tptr_pkg::IDX_SRC_SEL:  rd_byte = {7'h00, src_sel_r};
        default:                rd_byte = 8'h00;
      endcase
    end
  end

  // one-cycle ack, every address answered
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i)
        wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end

endmodule : tptr_top

// ### verif/tptr_fuse_model.sv
`timescale 1ns/1ns
module tptr_fuse_model #(
  parameter logic [5:0] BURNED = 6'h00
) (
  input  wire logic       clk_i,
  input  wire logic [5:0] blow_i,
  input  wire logic       sense_i,
  output logic [5:0]      value_o
);
  logic [5:0] fuse_r = BURNED;
  // a blown fuse stays blown; blow lines are unknown until reset first takes effect in the block
  always @(posedge clk_i)
  begin
    if (!$isunknown(blow_i))
      fuse_r <= fuse_r | blow_i;
  end
  // unsensed lines show the inverse, never the fuses
  assign value_o = sense_i ? fuse_r : ~fuse_r;
endmodule : tptr_fuse_model

// ### verif/tptr_props.sv
`timescale 1ns/1ns
module tptr_props (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_we_i,
  input wire logic       wb_ack_o,
  input wire logic       tx_line_if_powerdown_i,
  input wire logic       analog_test_mode_i,
  input wire logic       fuse_blow_pin_i,
  input wire logic [6:0] neg_current_trim_o,
  input wire logic [6:0] pos_current_trim_o,
  input wire logic [5:0] neg_fuse_blow_o,
  input wire logic [5:0] pos_fuse_blow_o,
  input wire logic       neg_fuse_override_o,
  input wire logic [2:0] tpl_rd_ui_i,
  input wire logic [4:0] tpl_rd_sample_i,
  input wire logic [6:0] tpl_rd_data_o
);
  logic       neg_ovr_exp;
  logic [5:0] neg_blow_exp;
  logic [5:0] pos_blow_exp;
  // fuse controls expected from the trim contents and pins
  assign neg_ovr_exp  = !neg_current_trim_o[0] && !fuse_blow_pin_i;
  assign neg_blow_exp = (!neg_current_trim_o[0] && fuse_blow_pin_i && analog_test_mode_i) ?
                        neg_current_trim_o[6:1] : 6'h00;
  assign pos_blow_exp = (!pos_current_trim_o[0] && fuse_blow_pin_i && analog_test_mode_i) ?
                        pos_current_trim_o[6:1] : 6'h00;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_pd2; tx_line_if_powerdown_i ##1 tx_line_if_powerdown_i; endsequence

  property p_ack; s_req |=> wb_ack_o ##1 !wb_ack_o; endproperty
  property p_blow_n; !tx_line_if_powerdown_i |=> neg_fuse_blow_o == $past(neg_blow_exp);
  endproperty
  property p_ovr_n; !tx_line_if_powerdown_i |=> neg_fuse_override_o == $past(neg_ovr_exp);
  endproperty
  property p_blow_p; !tx_line_if_powerdown_i |=> pos_fuse_blow_o == $past(pos_blow_exp);
  endproperty
  property p_pd; tx_line_if_powerdown_i |=> neg_current_trim_o == 7'h00 &&
    pos_current_trim_o == 7'h00 && neg_fuse_blow_o == 6'h00 && !neg_fuse_override_o;
  endproperty
  property p_pd_tpl; s_pd2 |=> tpl_rd_data_o == 7'h00; endproperty
  property p_bad_ui; tpl_rd_ui_i > 3'h4 |=> tpl_rd_data_o == 7'h00; endproperty
  property p_bad_smp; tpl_rd_sample_i > 5'h17 |=> tpl_rd_data_o == 7'h00; endproperty
  property p_hold; !(wb_cyc_i && wb_stb_i && wb_we_i) && !tx_line_if_powerdown_i |=>
    $stable(neg_current_trim_o) && $stable(pos_current_trim_o);
  endproperty

  a_ack: assert property (p_ack) else $error("ack not a single pulse");
  a_blow_n: assert property (p_blow_n) else $error("neg blow wrong");
  a_ovr_n: assert property (p_ovr_n) else $error("neg override wrong");
  a_blow_p: assert property (p_blow_p) else $error("pos blow wrong");
  a_pd: assert property (p_pd) else $error("powerdown did not clear");
  a_pd_tpl: assert property (p_pd_tpl) else $error("template not cleared");
  a_bad_ui: assert property (p_bad_ui) else $error("bad unit interval read");
  a_bad_smp: assert property (p_bad_smp) else $error("bad sample read");
  a_hold: assert property (p_hold) else $error("trim moved without write");
endmodule : tptr_props

bind tptr_top tptr_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
  .tx_line_if_powerdown_i, .analog_test_mode_i, .fuse_blow_pin_i, .neg_current_trim_o,
  .pos_current_trim_o, .neg_fuse_blow_o, .pos_fuse_blow_o, .neg_fuse_override_o,
  .tpl_rd_ui_i, .tpl_rd_sample_i, .tpl_rd_data_o);

// ### verif/tb.sv
`timescale 1ns/1ns
module tb;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, fuse_blow_pin_i;
  logic        tx_line_if_powerdown_i, analog_test_mode_i, neg_fuse_override_o;
  logic        pos_fuse_override_o, neg_fuse_sense_o, pos_fuse_sense_o;
  logic [11:0] wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [5:0]  neg_fuse_value_i, pos_fuse_value_i, neg_fuse_blow_o, pos_fuse_blow_o;
  logic [6:0]  neg_current_trim_o, pos_current_trim_o, tpl_rd_data_o;
  logic [2:0]  tpl_rd_ui_i;
  logic [4:0]  tpl_rd_sample_i;
  logic [7:0]  q;
  int          err_count, n_compared;

  tptr_top DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .tx_line_if_powerdown_i, .analog_test_mode_i,
    .fuse_blow_pin_i, .neg_fuse_value_i, .pos_fuse_value_i, .neg_current_trim_o,
    .pos_current_trim_o, .neg_fuse_blow_o, .pos_fuse_blow_o, .neg_fuse_override_o,
    .pos_fuse_override_o, .neg_fuse_sense_o, .pos_fuse_sense_o, .tpl_rd_ui_i,
    .tpl_rd_sample_i, .tpl_rd_data_o);
  tptr_fuse_model #(.BURNED(6'h15)) neg_fuse (.clk_i, .blow_i(neg_fuse_blow_o),
    .sense_i(neg_fuse_sense_o), .value_o(neg_fuse_value_i));
  tptr_fuse_model #(.BURNED(6'h0a)) pos_fuse (.clk_i, .blow_i(pos_fuse_blow_o),
    .sense_i(pos_fuse_sense_o), .value_o(pos_fuse_value_i));

  // free-running clock
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20)
    begin
      err_count++;
      finish_test();
    end
  endtask : wb

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), q, e);
  endtask : rd

  task automatic tpl(input logic [2:0] u, input logic [4:0] s, input logic [6:0] e);
    @(posedge clk_i);
    tpl_rd_ui_i     <= u;
    tpl_rd_sample_i <= s;
    @(posedge clk_i);
    @(negedge clk_i);
    chk($sformatf("entry %0d %0d", u, s), {1'b0, tpl_rd_data_o}, {1'b0, e});
  endtask : tpl

  task automatic t_regs;
    logic [11:0] ra [6] = '{12'h3c8, 12'h3cc, 12'h3d0, 12'h3d4, 12'h3d8, 12'h3e0};
    foreach (ra[i]) rd(ra[i], 8'h00);
    wb(1'b1, 12'h3c8, 8'hbc);
    rd(12'h3c8, 8'hbc);
  endtask : t_regs

  task automatic t_tpl;
    logic [7:0] a [4] = '{8'h00, 8'hbc, 8'h2a, 8'h0b};
    logic [6:0] v [4] = '{7'h3f, 7'h7e, 7'h40, 7'h05};
    logic [6:0] e [4] = '{7'h3f, 7'h42, 7'h00, 7'h05};
    foreach (a[i]) wb(1'b1, 12'h3c8, a[i]);
    foreach (a[i]) wb(1'b1, 12'h3cc, {1'b0, v[i]});
    foreach (a[i])
    begin
      wb(1'b1, 12'h3c8, a[i]);
      wb(1'b1, 12'h3cc, {1'b0, v[i]});
    end
    wb(1'b1, 12'h3c8, 8'hc0);
    wb(1'b1, 12'h3cc, 8'h11);
    wb(1'b1, 12'h3c8, 8'hbf);
    wb(1'b1, 12'h3cc, 8'h11);
    wb(1'b1, 12'h3c8, 8'h00);
    wb(1'b1, 12'h3cc, 8'h7f);
    foreach (a[i]) tpl(a[i][2:0], a[i][7:3], e[i]);
    tpl(3'h1, 5'h00, 7'h00);
    tpl(3'h2, 5'h0f, 7'h00);
    tpl(3'h5, 5'h00, 7'h00);
    tpl(3'h0, 5'h18, 7'h00);
  endtask : t_tpl

  task automatic t_trim;
    wb(1'b1, 12'h3d8, 8'h01);
    rd(12'h3d8, 8'h01);
    wb(1'b1, 12'h3d0, 8'hda);
    wb(1'b1, 12'h3d4, 8'h24);
    rd(12'h3d0, 8'h5a);
    rd(12'h3d4, 8'h24);
    @(negedge clk_i);
    chk("neg override", {7'h00, neg_fuse_override_o}, 8'h01);
    chk("pos override", {7'h00, pos_fuse_override_o}, 8'h01);
    @(posedge clk_i);
    fuse_blow_pin_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    chk("neg blow off", {2'b00, neg_fuse_blow_o}, 8'h00);
    @(posedge clk_i);
    analog_test_mode_i <= 1'b1;
    @(posedge clk_i);
    @(negedge clk_i);
    chk("neg blow", {2'b00, neg_fuse_blow_o}, 8'h2d);
    chk("pos blow", {2'b00, pos_fuse_blow_o}, 8'h12);
    @(posedge clk_i);
    fuse_blow_pin_i    <= 1'b0;
    analog_test_mode_i <= 1'b0;
  endtask : t_trim

  task automatic t_copy;
    wb(1'b1, 12'h3d0, 8'h01);
    wb(1'b1, 12'h3d4, 8'h01);
    wb(1'b1, 12'h3d8, 8'h00);
    wb(1'b1, 12'h3d0, 8'hff);
    wb(1'b1, 12'h3d8, 8'h00);
    wb(1'b1, 12'h3d0, 8'hff);
    @(negedge clk_i);
    chk("neg sense", {7'h00, neg_fuse_sense_o}, 8'h01);
    rd(12'h3d0, 8'h01);
    wb(1'b1, 12'h3d0, 8'h00);
    rd(12'h3d0, 8'h7b);
    wb(1'b1, 12'h3d4, 8'h00);
    @(negedge clk_i);
    chk("pos sense", {7'h00, pos_fuse_sense_o}, 8'h01);
    wb(1'b1, 12'h3d4, 8'h00);
    chk("pos sense off", {7'h00, pos_fuse_sense_o}, 8'h00);
    rd(12'h3d4, 8'h35);
    wb(1'b1, 12'h3d8, 8'h01);
    wb(1'b1, 12'h3d0, 8'h00);
    wb(1'b1, 12'h3d4, 8'h00);
  endtask : t_copy

  task automatic t_pd;
    wb(1'b1, 12'h3c8, 8'h5b);
    wb(1'b1, 12'h3d0, 8'h5a);
    rd(12'h3d0, 8'h5a);
    @(posedge clk_i);
    tx_line_if_powerdown_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    tx_line_if_powerdown_i <= 1'b0;
    rd(12'h3c8, 8'h00);
    rd(12'h3d0, 8'h00);
    rd(12'h3d8, 8'h00);
    tpl(3'h4, 5'h17, 7'h00);
  endtask : t_pd

  // reset, then the scenarios in turn
  initial
  begin
    {wb_cyc_i, wb_stb_i, wb_we_i, tx_line_if_powerdown_i} = 4'h0;
    {analog_test_mode_i, fuse_blow_pin_i} = 2'b00;
    {wb_adr_i, wb_dat_i, tpl_rd_ui_i, tpl_rd_sample_i} = '0;
    wb_sel_i = 4'hf;
    rst_i    = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_tpl();
    t_trim();
    t_copy();
    t_pd();
    finish_test();
  end
endmodule : tb
